// ===== rtl/dtdl_decision.sv
// Purpose: Trip decision logic of a transformer differential protection function
// Assumes: All status inputs come from comparators on clk_i, so none is synchronised
// Notes:   Measured quantities do not pass through here and are never blocked
// Behaviour
// R1: A true blocking input forces every start output false while measurements go on.
// R2: Each phase restrained start is true only while its characteristic start is true and unblocked.
// R3: The general restrained start is the OR of the phase restrained starts, false when blocked.
// R4: Each phase highset start is true only while its high-current start is true and unblocked.
// R5: The general highset start is true while any phase exceeds the high current unblocked.
// R6: The inrush output is true while any phase has an effective second harmonic restraint.
// R7: The fifth harmonic output is true while any phase has fifth harmonic restraint.
// R8: The adaptive characteristic is entered once bias above 1.25 In holds 3 ms with low diff.
// R9: The adaptive characteristic stays latched until bias falls below 0.8 In.
// R10: While adaptive, the slopes presented to the comparator are 50 and 200 percent.
// R11: Second harmonic restraint counts only while the phase angle check reports 75 degrees or more.
// R12: The general starts are driven out to the fast trip equation logic, which consumes them.
// R13: The inputs are the phase starts, highset starts, second and fifth restraints and the block.
// R14: Harmonic restraint suppresses the restrained start of its phase but never the highset start.
// R15: The 3 ms wait counts sampling ticks and restarts whenever an entry condition is lost.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module dtdl_decision
  import dtdl_pkg::*;
#(
  parameter int SAMPLE_DIV_P = SAMPLE_DIV,
  parameter int QUAL_TICKS_P = ADAPT_QUAL_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        user_block_input_i,
  input  wire logic [2:0]  restrained_raw_i,
  input  wire logic [2:0]  highset_raw_i,
  input  wire logic [2:0]  inrush_raw_i,
  input  wire logic [2:0]  fifth_raw_i,
  input  wire logic        angle_external_i,
  input  wire logic [2:0]  bias_entry_i,
  input  wire logic [2:0]  diff_below_base_i,
  input  wire logic [2:0]  bias_release_i,
  output logic             restrained_start_phase1_o,
  output logic             restrained_start_phase2_o,
  output logic             restrained_start_phase3_o,
  output logic             restrained_start_any_o,
  output logic             highset_start_phase1_o,
  output logic             highset_start_phase2_o,
  output logic             highset_start_phase3_o,
  output logic             highset_start_any_o,
  output logic             inrush_restraint_any_o,
  output logic             fifth_harmonic_restraint_any_o,
  output logic             adaptive_active_o,
  output logic      [7:0]  slope_first_o,
  output logic      [7:0]  slope_second_o,
  output logic             irq_o
);

  localparam int DIV_W = $clog2(SAMPLE_DIV_P + 1);
  localparam int CNT_W = $clog2(QUAL_TICKS_P + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV_P - 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(QUAL_TICKS_P);

  // Sampling tick divider
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             tick;

  always_comb begin
    tick         = (div_cnt == DIV_LAST);
    next_div_cnt = tick ? '0 : div_cnt + DIV_W'(1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Registers
  logic [2:0]       ctrl;
  logic [15:0]      slope;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic             ack;
  logic [31:0]      rdata;
  dtdl_dec_t        dec;
  dtdl_adapt_t      adapt_st;
  logic [CNT_W-1:0] qual_cnt;

  logic [2:0]       next_ctrl;
  logic [15:0]      next_slope;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic             next_ack;
  logic [31:0]      next_rdata;
  dtdl_dec_t        next_dec;
  dtdl_adapt_t      next_adapt_st;
  logic [CNT_W-1:0] next_qual_cnt;

  logic             access;
  logic             wr;
  logic [31:0]      wmask;
  logic             blocked;
  logic [2:0]       second_eff;
  logic             entry;
  logic             release_all;
  logic [IRQ_W-1:0] events;

  // Decision path
  always_comb begin
    blocked    = user_block_input_i | ctrl[CTRL_SOFT_BLK];
    // Without the gate the second harmonic would also restrain internal faults
    second_eff = ctrl[CTRL_ANGLE_GATE] ? (inrush_raw_i & {3{angle_external_i}})
                                       : inrush_raw_i;                            // [R11]
    next_dec            = '0;
    next_dec.blocked    = blocked;
    next_dec.restrained = restrained_raw_i & ~second_eff & ~fifth_raw_i
                          & ~{3{blocked}};                                        // [R2] [R14] [R13]
    next_dec.highset    = highset_raw_i & ~{3{blocked}};                          // [R4] [R14]
    next_dec.restrained_any = (|next_dec.restrained) & ~blocked;                  // [R3] [R1]
    next_dec.highset_any    = (|highset_raw_i) & ~blocked;                        // [R5] [R1]
    next_dec.inrush_any     = |second_eff;                                        // [R6]
    next_dec.fifth_any      = |fifth_raw_i;                                       // [R7]
    next_dec.adaptive       = (next_adapt_st == DTDL_ADAPT);
  end

  // Adaptive characteristic switch
  always_comb begin
    entry         = (|(bias_entry_i & diff_below_base_i)) & ctrl[CTRL_ADAPT_EN];
    release_all   = &bias_release_i;
    next_adapt_st = adapt_st;
    next_qual_cnt = qual_cnt;
    unique case (adapt_st)
      DTDL_IDLE: begin
        next_qual_cnt = '0;
        if (entry) begin
          next_adapt_st = DTDL_QUAL;
        end
      end
      DTDL_QUAL: begin
        if (!entry) begin
          next_adapt_st = DTDL_IDLE;                                              // [R15]
          next_qual_cnt = '0;                                                     // [R15]
        end else if (tick) begin
          // One extra tick covers the partial first period, so the wait is never short
          if (qual_cnt == CNT_LAST) begin
            next_adapt_st = DTDL_ADAPT;                                           // [R8]
            next_qual_cnt = '0;
          end else begin
            next_qual_cnt = qual_cnt + CNT_W'(1);                                 // [R15]
          end
        end
      end
      DTDL_ADAPT: begin
        if (release_all || !ctrl[CTRL_ADAPT_EN]) begin
          next_adapt_st = DTDL_IDLE;                                              // [R9]
        end
      end
      default: begin
        next_adapt_st = DTDL_IDLE;
        next_qual_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adapt_st <= DTDL_IDLE;
      qual_cnt <= '0;
      dec      <= '0;
    end else begin
      adapt_st <= next_adapt_st;
      qual_cnt <= next_qual_cnt;
      dec      <= next_dec;
    end
  end

  // Wishbone slave and register file
  always_comb begin
    access  = wb_cyc_i & wb_stb_i & ~ack;
    wr      = access & wb_we_i;
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    next_ack = access;
    next_ctrl     = ctrl;
    next_slope    = slope;
    next_irq_mask = irq_mask;
    events = '0;
    events[IRQ_RESTRAINED] = next_dec.restrained_any & ~dec.restrained_any;
    events[IRQ_HIGHSET]    = next_dec.highset_any & ~dec.highset_any;
    events[IRQ_ADAPT]      = next_dec.adaptive & ~dec.adaptive;
    next_irq_stat = irq_stat;
    if (wr && wb_adr_i == ADR_CTRL) begin
      next_ctrl = (ctrl & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
    end
    if (wr && wb_adr_i == ADR_SLOPE) begin
      next_slope = (slope & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
    end
    if (wr && wb_adr_i == ADR_IRQ_MASK) begin
      next_irq_mask = (irq_mask & ~wmask[IRQ_W-1:0]) | (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
    if (wr && wb_adr_i == ADR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~(wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    next_rdata = rdata;
    if (access) begin
      next_rdata = '0;
      unique case (wb_adr_i)
        ADR_CTRL:     next_rdata[2:0]       = ctrl;
        ADR_SLOPE:    next_rdata[15:0]      = slope;
        ADR_STATUS:   next_rdata[$bits(dtdl_dec_t)-1:0] = dec;
        ADR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
        ADR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
        default:      next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      rdata    <= '0;
      ctrl     <= CTRL_RESET;
      slope    <= SLOPE_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      ack      <= next_ack;
      rdata    <= next_rdata;
      ctrl     <= next_ctrl;
      slope    <= next_slope;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // Outputs to the fast trip logic and the comparators
  always_comb begin
    wb_ack_o                       = ack;
    wb_dat_o                       = rdata;
    restrained_start_phase1_o      = dec.restrained[0];
    restrained_start_phase2_o      = dec.restrained[1];
    restrained_start_phase3_o      = dec.restrained[2];
    restrained_start_any_o         = dec.restrained_any;                          // [R12]
    highset_start_phase1_o         = dec.highset[0];
    highset_start_phase2_o         = dec.highset[1];
    highset_start_phase3_o         = dec.highset[2];
    highset_start_any_o            = dec.highset_any;                             // [R12]
    inrush_restraint_any_o         = dec.inrush_any;
    fifth_harmonic_restraint_any_o = dec.fifth_any;
    adaptive_active_o              = dec.adaptive;
    slope_first_o  = dec.adaptive ? ADAPT_SLOPE1_PCT : slope[SLOPE1_LSB +: 8];    // [R10]
    slope_second_o = dec.adaptive ? ADAPT_SLOPE2_PCT : slope[SLOPE2_LSB +: 8];    // [R10]
    irq_o          = |(irq_stat & irq_mask);
  end

endmodule : dtdl_decision

// ===== rtl/dtdl_pkg.sv
// Purpose: Shared constants and types of the differential trip decision logic
// Assumes: 10 MHz system clock, 32-bit classic Wishbone register access
// Notes:   Register offsets are byte addresses of aligned words
package dtdl_pkg;

  // Clock and sampling tick
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_DIV       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Adaptive characteristic qualification, least time rounds up
  localparam int ADAPT_QUAL_MS    = 3;
  localparam int ADAPT_QUAL_TICKS = (ADAPT_QUAL_MS * 1000000 + SAMPLE_PERIOD_NS - 1)
                                    / SAMPLE_PERIOD_NS;

  // Slopes in percent used while the adaptive characteristic holds
  localparam logic [7:0] ADAPT_SLOPE1_PCT = 8'h32;
  localparam logic [7:0] ADAPT_SLOPE2_PCT = 8'hC8;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_SLOPE     = 8'h04;
  localparam logic [7:0] ADR_STATUS    = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h10;

  // Control fields
  localparam int CTRL_ADAPT_EN  = 0;
  localparam int CTRL_SOFT_BLK  = 1;
  localparam int CTRL_ANGLE_GATE = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;

  // Configured slopes, first in bits 7:0, second in bits 15:8
  localparam int SLOPE1_LSB = 0;
  localparam int SLOPE2_LSB = 8;
  localparam logic [15:0] SLOPE_RESET = 16'h3214;

  // Interrupt event bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_RESTRAINED = 0;
  localparam int IRQ_HIGHSET   = 1;
  localparam int IRQ_ADAPT     = 2;

  typedef struct packed {
    logic       blocked;
    logic       adaptive;
    logic       fifth_any;
    logic       inrush_any;
    logic       highset_any;
    logic       restrained_any;
    logic [2:0] highset;
    logic [2:0] restrained;
  } dtdl_dec_t;

  typedef enum logic [1:0] {
    DTDL_IDLE  = 2'b00,
    DTDL_QUAL  = 2'b01,
    DTDL_ADAPT = 2'b11
  } dtdl_adapt_t;

endpackage : dtdl_pkg

// ===== verif/dtdl_checker.sv
// Purpose: Concurrent checks on the decision outputs
// Assumes: Bound to dtdl_decision, single clock domain
// Notes:   Bus timing is left to the bench tasks
`timescale 1ns/100ps
module dtdl_checker
  import dtdl_pkg::*;
#(
  parameter int SAMPLE_DIV_P = SAMPLE_DIV,
  parameter int QUAL_TICKS_P = ADAPT_QUAL_TICKS
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       user_block_input_i,
  input wire logic [2:0] restrained_raw_i,
  input wire logic [2:0] highset_raw_i,
  input wire logic [2:0] inrush_raw_i,
  input wire logic [2:0] fifth_raw_i,
  input wire logic [2:0] bias_entry_i,
  input wire logic [2:0] diff_below_base_i,
  input wire logic [2:0] bias_release_i,
  input wire logic       restrained_start_phase1_o,
  input wire logic       restrained_start_any_o,
  input wire logic       highset_start_phase2_o,
  input wire logic       highset_start_any_o,
  input wire logic       inrush_restraint_any_o,
  input wire logic       fifth_harmonic_restraint_any_o,
  input wire logic       adaptive_active_o,
  input wire logic [7:0] slope_first_o,
  input wire logic [7:0] slope_second_o
);
  // Cycles of unbroken entry condition, the floor for any adaptive switch
  int run;
  int next_run;
  always_comb begin
    next_run = (|(bias_entry_i & diff_below_base_i)) ? run + 1 : 0;
  end
  always_ff @(posedge clk_i) begin
    run <= rst_i ? 0 : next_run;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_block_starts: assert property (user_block_input_i |=>
    !restrained_start_any_o && !highset_start_any_o) else $error("start while blocked");
  chk_phase_cause: assert property (restrained_start_phase1_o |-> $past(
    restrained_raw_i[0] && !fifth_raw_i[0] && !user_block_input_i)) else $error("bad start");
  chk_hs_cause: assert property (highset_start_phase2_o |->
    $past(highset_raw_i[1] && !user_block_input_i)) else $error("bad highset start");
  chk_inrush_cause: assert property (inrush_restraint_any_o |->
    $past(|inrush_raw_i)) else $error("inrush without cause");
  chk_fifth_any: assert property (!$past(rst_i) |->
    fifth_harmonic_restraint_any_o == $past(|fifth_raw_i)) else $error("fifth mismatch");
  chk_adapt_qual: assert property ($rose(adaptive_active_o) |->
    run >= QUAL_TICKS_P * SAMPLE_DIV_P) else $error("adaptive too early");
  chk_adapt_hold: assert property (adaptive_active_o && !(&bias_release_i)
    && !$past(&bias_release_i) |=> adaptive_active_o) else $error("adaptive dropped");
  chk_slope_adapt: assert property (adaptive_active_o && $past(adaptive_active_o) |->
    $past(slope_first_o) == ADAPT_SLOPE1_PCT && $past(slope_second_o) == ADAPT_SLOPE2_PCT)
    else $error("adaptive slopes wrong");
  cov_adapt: cover property ($rose(adaptive_active_o));
  cov_highset: cover property ($rose(highset_start_any_o));
  cov_block: cover property (user_block_input_i && $past(restrained_raw_i != 3'h0));
endmodule : dtdl_checker

// ===== verif/dtdl_fast_trip.sv
// Purpose: Fast trip equation model on the far side of the general starts
// Assumes: Same clock domain as the decision logic
// Notes:   Combinational so the bench sees trip with the starts
`timescale 1ns/100ps
module dtdl_fast_trip (
  input  wire logic restrained_start_any_i,
  input  wire logic highset_start_any_i,
  output logic      trip_o
);
  always_comb begin
    trip_o = restrained_start_any_i | highset_start_any_i;
  end
endmodule : dtdl_fast_trip

// ===== verif/dtdl_decision_tb.sv
// Purpose: Self-checking bench of the differential trip decision logic
// Assumes: Short tick and qualification parameters keep the adaptive wait small
// Notes:   Bench plays the upstream comparators, trip model is the far side
`timescale 1ns/100ps
module dtdl_decision_tb;
  import dtdl_pkg::*;
  localparam int DIV = 2;
  localparam int QT  = 4;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, user_block_input_i, angle_external_i;
  logic        wb_ack_o, irq_o, adaptive_active_o, trip, highset_start_any_o;
  logic        restrained_start_phase1_o, restrained_start_phase2_o, restrained_start_phase3_o;
  logic        highset_start_phase1_o, highset_start_phase2_o, highset_start_phase3_o;
  logic        restrained_start_any_o, inrush_restraint_any_o, fifth_harmonic_restraint_any_o;
  logic [7:0]  wb_adr_i, slope_first_o, slope_second_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, obs;
  logic [2:0]  restrained_raw_i, highset_raw_i, inrush_raw_i, fifth_raw_i;
  logic [2:0]  bias_entry_i, diff_below_base_i, bias_release_i;
  logic        gate_on, soft_blk;
  int          fails, n_tests, i;
  // Row fields from bit 14 down: starts, highset, second, fifth, block, angle, spare
  logic [14:0] tbl [7] = '{15'h1000, 15'h7004, 15'h2482, 15'h2080, 15'h4820, 15'h0FFE, 15'h6004};
  assign obs = {21'h0, restrained_start_any_o, restrained_start_phase3_o,
    restrained_start_phase2_o, restrained_start_phase1_o, highset_start_any_o,
    highset_start_phase3_o, highset_start_phase2_o, highset_start_phase1_o,
    inrush_restraint_any_o, fifth_harmonic_restraint_any_o, trip};
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  dtdl_decision #(.SAMPLE_DIV_P(DIV), .QUAL_TICKS_P(QT)) dtdl_decision_inst (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .user_block_input_i, .restrained_raw_i, .highset_raw_i, .inrush_raw_i, .fifth_raw_i,
    .angle_external_i, .bias_entry_i, .diff_below_base_i, .bias_release_i,
    .restrained_start_phase1_o, .restrained_start_phase2_o, .restrained_start_phase3_o,
    .restrained_start_any_o, .highset_start_phase1_o, .highset_start_phase2_o,
    .highset_start_phase3_o, .highset_start_any_o, .inrush_restraint_any_o,
    .fifth_harmonic_restraint_any_o, .adaptive_active_o, .slope_first_o, .slope_second_o,
    .irq_o);
  dtdl_fast_trip dtdl_fast_trip_inst (.restrained_start_any_i(restrained_start_any_o),
    .highset_start_any_i(highset_start_any_o), .trip_o(trip));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is seen; a stuck slave ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1) begin
      fails++;
      close_out();
    end
  endtask : wb
  function automatic logic [31:0] expv(input logic [14:0] c);
    logic [2:0] r, h, s;
    logic       b;
    // With the angle gate off every second harmonic restraint counts
    s = c[8:6] & {3{c[1] | ~gate_on}};
    b = c[2] | soft_blk;
    r = c[14:12] & ~s & ~c[5:3] & {3{~b}};
    h = c[11:9] & {3{~b}};
    return {21'h0, |r, r, |h, h, |s, |c[5:3], |{r, h}};
  endfunction : expv
  task automatic step(input logic [14:0] c);
    @(posedge clk_i);
    {restrained_raw_i, highset_raw_i, inrush_raw_i, fifth_raw_i, user_block_input_i,
      angle_external_i} <= c[14:1];
    @(posedge clk_i);
    #1;
    chk(obs, expv(c));
  endtask : step
  initial begin
    fails = 0;
    n_tests = 0;
    gate_on = CTRL_RESET[CTRL_ANGLE_GATE];
    soft_blk = CTRL_RESET[CTRL_SOFT_BLK];
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {restrained_raw_i, highset_raw_i, inrush_raw_i, fifth_raw_i, user_block_input_i} = '0;
    {angle_external_i, bias_entry_i, diff_below_base_i, bias_release_i} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, {29'h0, CTRL_RESET});
    wb(1'b0, ADR_SLOPE, 32'h0);
    chk(rd, {16'h0, SLOPE_RESET});
    chk({16'h0, slope_second_o, slope_first_o}, {16'h0, SLOPE_RESET});
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 7; i++) begin
      step(tbl[i]);
    end
    $display("test registers and decision table done");
    wb(1'b1, ADR_IRQ_MASK, 32'h2);
    wb(1'b1, ADR_IRQ_STAT, 32'h7);
    step(15'h1000);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(rd, 32'h41);
    step(15'h1200);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    wb(1'b1, ADR_IRQ_STAT, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    // Entry broken once mid-count so a counter that is not cleared shows up early
    {bias_entry_i, diff_below_base_i} <= 6'b010010;
    repeat (QT * DIV) @(posedge clk_i);
    bias_entry_i <= 3'b000;
    @(posedge clk_i);
    bias_entry_i <= 3'b010;
    i = 0;
    while (adaptive_active_o !== 1'b1 && i < 100) begin
      @(posedge clk_i);
      i++;
    end
    if (adaptive_active_o !== 1'b1) begin
      fails++;
      close_out();
    end
    chk({31'h0, i >= QT * DIV && i <= (QT + 2) * DIV + 3}, 32'h1);
    chk({16'h0, slope_second_o, slope_first_o},
      {16'h0, ADAPT_SLOPE2_PCT, ADAPT_SLOPE1_PCT});
    {bias_entry_i, bias_release_i} <= 6'b000011;
    repeat (10) @(posedge clk_i);
    chk({31'h0, adaptive_active_o}, 32'h1);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    chk(rd, 32'h4);
    bias_release_i <= 3'b111;
    repeat (3) @(posedge clk_i);
    #1;
    chk({31'h0, adaptive_active_o}, 32'h0);
    $display("test interrupt and adaptive done");
    gate_on = 1'b0;
    wb(1'b1, ADR_CTRL, 32'h0);
    step(15'h1040);
    soft_blk = 1'b1;
    wb(1'b1, ADR_CTRL, 32'h2);
    step(15'h1200);
    wb(1'b1, ADR_SLOPE, 32'h5A1E);
    chk({16'h0, slope_second_o, slope_first_o}, 32'h5A1E);
    $display("test control modes done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    gate_on = CTRL_RESET[CTRL_ANGLE_GATE];
    soft_blk = CTRL_RESET[CTRL_SOFT_BLK];
    repeat (2) @(posedge clk_i);
    #1;
    chk(obs, 32'h0);
    chk({16'h0, slope_second_o, slope_first_o}, {16'h0, SLOPE_RESET});
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, {29'h0, CTRL_RESET});
    step(15'h1200);
    $display("test second reset done");
    close_out();
  end
endmodule : dtdl_decision_tb
bind dtdl_decision dtdl_checker #(.SAMPLE_DIV_P(SAMPLE_DIV_P), .QUAL_TICKS_P(QUAL_TICKS_P))
  dtdl_checker_inst (.clk_i, .rst_i, .user_block_input_i, .restrained_raw_i, .highset_raw_i,
  .inrush_raw_i, .fifth_raw_i, .bias_entry_i, .diff_below_base_i, .bias_release_i,
  .restrained_start_phase1_o, .restrained_start_any_o, .highset_start_phase2_o,
  .highset_start_any_o, .inrush_restraint_any_o, .fifth_harmonic_restraint_any_o,
  .adaptive_active_o, .slope_first_o, .slope_second_o);
